// ---- logic/cce_params.svh ----
// Purpose: Constants for the capture/compare extras block
// Assumes: Parameter access by index on a simple host parameter port
// Notes:   Offsets are parameter addresses (word index of 32-bit entries)
`ifndef CCE_PARAMS_SVH
`define CCE_PARAMS_SVH

// ==========================================================================
// Parameter addresses
`define CCE_ADDR_OPTIONS      16'h0126
`define CCE_ADDR_MASK_DIST    16'h0128
`define CCE_ADDR_FIXED_OFS    16'h012E
`define CCE_ADDR_ONESHOT_OFS  16'h0130
`define CCE_ADDR_ARRAY_START  16'h0140
`define CCE_ADDR_CMP_VALUE    16'h0142

// ==========================================================================
// Field positions and limits
`define CCE_CAP_REPEAT_BIT    0
`define CCE_CMP_AUTOCLR_BIT   8
`define CCE_MASK_DIST_MAX     32'h05F5_E100
`define CCE_OPTIONS_RST       16'h0000
`define CCE_MASK_DIST_RST     32'h0000_0000
`define CCE_OFS_RST           32'h0000_0000
`define CCE_START_RST         8'h00

`endif

// ---- logic/cce_pkg.sv ----
// Purpose: Types for the capture/compare extras block
// Assumes: Constants come from cce_params.svh
// Notes:   Carrier structs for parameter access and capture events
package cce_pkg;

  // ========================================================================
  // Host parameter access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } cce_par_req_t;

  // Capture engine write into the data array
  typedef struct packed {
    logic        valid;
    logic [7:0]  index;
    logic [31:0] pos;
  } cce_cap_wr_t;

  // Capture sequencer states
  typedef enum logic [1:0] {
    CCE_IDLE = 2'b00,
    CCE_RUN  = 2'b01,
    CCE_MASK = 2'b10
  } cce_state_t;

endpackage

// ---- logic/cce_cmp_calc.sv ----
// Purpose: Registered sum forming the effective compare value
// Assumes: Inputs valid in the cycle of the strobe
// Notes:   One cycle latency from strobe to result
`timescale 1ns/1ps
`default_nettype none

module cce_cmp_calc (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        calc,
  input  wire logic [31:0] array_val,
  input  wire logic [31:0] fixed_ofs,
  input  wire logic [31:0] oneshot_ofs,
  output var  logic [31:0] effective_compare_value,
  output var  logic        value_valid
);

  // ========================================================================
  // Sum of entry and both offsets, modulo 2^32
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      effective_compare_value <= 32'h0000_0000;
      value_valid             <= 1'b0;
    end else begin
      value_valid <= calc;
      if (calc) begin
        effective_compare_value <= array_val + fixed_ofs + oneshot_ofs;
      end
    end
  end

endmodule

`default_nettype wire

// ---- logic/cce_top.sv ----
// Purpose: Capture repeat, capture masking and one-shot compare offset
// Assumes: Position and triggers synchronous to clk_sys; host access by address
// Notes:   Data array held locally; compare engine asks for one value at a time
`timescale 1ns/1ps
`default_nettype none
`include "cce_params.svh"

module cce_top #(
  parameter int ARRAY_DEPTH = 256
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire cce_pkg::cce_par_req_t par_req,
  output var  logic [31:0]          par_rdata,
  output var  logic                 par_rvalid,
  input  wire logic                 cap_start,
  input  wire logic [7:0]           cap_count,
  input  wire logic                 cap_trig,
  input  wire logic [31:0]          axis_pos,
  output var  cce_pkg::cce_cap_wr_t cap_wr,
  output var  logic                 cap_busy,
  input  wire logic                 cmp_req,
  input  wire logic [7:0]           cmp_index,
  output var  logic [31:0]          effective_compare_value,
  output var  logic                 cmp_valid
);
  import cce_pkg::*;

  logic [15:0] capture_compare_extra_options_ff;
  logic [31:0] capture_mask_distance_ff;
  logic [31:0] fixed_compare_offset_ff;
  logic [31:0] oneshot_compare_offset_ff;
  logic [7:0]  capture_array_start_ff;
  logic [31:0] data_array [ARRAY_DEPTH];
  cce_state_t  state_ff;
  logic [7:0]  index_ff;
  logic [7:0]  left_ff;
  logic [31:0] mask_origin_ff;
  logic        repeat_en;
  logic        autoclr_en;
  logic        trig_ok;
  logic        take;
  logic        last_pt;
  logic        oneshot_wr;

  // Absolute distance between two positions
  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    abs_diff = d[31] ? (32'h0000_0000 - d) : d;
  endfunction

  // ========================================================================
  // Option decode
  assign repeat_en  = capture_compare_extra_options_ff[`CCE_CAP_REPEAT_BIT];
  assign autoclr_en = capture_compare_extra_options_ff[`CCE_CMP_AUTOCLR_BIT];
  assign oneshot_wr = par_req.wr && (par_req.addr == `CCE_ADDR_ONESHOT_OFS);

  // ========================================================================
  // Parameter writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      capture_compare_extra_options_ff <= `CCE_OPTIONS_RST;
      capture_mask_distance_ff         <= `CCE_MASK_DIST_RST;
      fixed_compare_offset_ff          <= `CCE_OFS_RST;
      capture_array_start_ff           <= `CCE_START_RST;
    end else if (par_req.wr) begin
      unique case (par_req.addr)
        `CCE_ADDR_OPTIONS: begin
          capture_compare_extra_options_ff <= par_req.wdata[15:0];
        end
        `CCE_ADDR_MASK_DIST: begin
          // Out-of-range settings are refused, value kept
          if (par_req.wdata <= `CCE_MASK_DIST_MAX) begin
            capture_mask_distance_ff <= par_req.wdata;
          end
        end
        `CCE_ADDR_FIXED_OFS: begin
          fixed_compare_offset_ff <= par_req.wdata;
        end
        `CCE_ADDR_ARRAY_START: begin
          capture_array_start_ff <= par_req.wdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // One-shot offset: new write wins over the automatic clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oneshot_compare_offset_ff <= `CCE_OFS_RST;
    end else if (oneshot_wr) begin
      oneshot_compare_offset_ff <= par_req.wdata;
    end else if (cmp_req && autoclr_en) begin
      oneshot_compare_offset_ff <= `CCE_OFS_RST;
    end
  end
  // Without autoclear the offset is simply held

  // ========================================================================
  // Parameter reads, one cycle later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      par_rdata  <= 32'h0000_0000;
      par_rvalid <= 1'b0;
    end else begin
      par_rvalid <= par_req.rd;
      if (par_req.rd) begin
        unique case (par_req.addr)
          `CCE_ADDR_OPTIONS:     par_rdata <= {16'h0000, capture_compare_extra_options_ff};
          `CCE_ADDR_MASK_DIST:   par_rdata <= capture_mask_distance_ff;
          `CCE_ADDR_FIXED_OFS:   par_rdata <= fixed_compare_offset_ff;
          `CCE_ADDR_ONESHOT_OFS: par_rdata <= oneshot_compare_offset_ff;
          `CCE_ADDR_ARRAY_START: par_rdata <= {24'h00_0000, capture_array_start_ff};
          `CCE_ADDR_CMP_VALUE:   par_rdata <= effective_compare_value;
          default:               par_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ========================================================================
  // Capture gating and masking window
  assign trig_ok = (capture_mask_distance_ff == 32'h0000_0000) ||
                   (abs_diff(axis_pos, mask_origin_ff) > capture_mask_distance_ff);
  assign take    = cap_trig && ((state_ff == CCE_RUN) || (state_ff == CCE_MASK && trig_ok));
  assign last_pt = (left_ff == 8'h01);

  // ========================================================================
  // Capture sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff       <= CCE_IDLE;
      index_ff       <= 8'h00;
      left_ff        <= 8'h00;
      mask_origin_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        CCE_IDLE: begin
          if (cap_start && cap_count != 8'h00) begin
            state_ff <= CCE_RUN;
            index_ff <= capture_array_start_ff;
            left_ff  <= cap_count;
          end
        end
        CCE_RUN, CCE_MASK: begin
          if (take) begin
            mask_origin_ff <= axis_pos;
            if (last_pt && repeat_en) begin
              index_ff <= capture_array_start_ff;
              left_ff  <= cap_count;
              state_ff <= CCE_MASK;
            end else if (last_pt) begin
              state_ff <= CCE_IDLE;
            end else begin
              index_ff <= index_ff + 8'h01;
              left_ff  <= left_ff - 8'h01;
              state_ff <= CCE_MASK;
            end
          end
        end
        default: begin
          state_ff <= CCE_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Data array: captured positions and compare reads
  always_ff @(posedge clk_sys) begin
    if (take) begin
      data_array[index_ff] <= axis_pos;
    end
  end

  // Capture write report to the base engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_wr <= '0;
    end else begin
      cap_wr.valid <= take;
      cap_wr.index <= index_ff;
      cap_wr.pos   <= axis_pos;
    end
  end

  assign cap_busy = (state_ff != CCE_IDLE);

  // ========================================================================
  // Effective compare value
  cce_cmp_calc u_calc (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .calc                    (cmp_req),
    .array_val               (data_array[cmp_index]),
    .fixed_ofs               (fixed_compare_offset_ff),
    .oneshot_ofs             (oneshot_compare_offset_ff),
    .effective_compare_value (effective_compare_value),
    .value_valid             (cmp_valid)
  );

  // ========================================================================
  // Assertions
  sequence oneshot_used_s;
    cmp_req && autoclr_en && !oneshot_wr;
  endsequence

  oneshot_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    oneshot_used_s |=> (oneshot_compare_offset_ff == 32'h0000_0000))
    else $error("one-shot offset not cleared after use");

  oneshot_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!autoclr_en && !oneshot_wr) |=> $stable(oneshot_compare_offset_ff))
    else $error("one-shot offset changed without autoclear");

  cmp_sum_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_req |=> cmp_valid && effective_compare_value ==
      $past(data_array[cmp_index]) + $past(fixed_compare_offset_ff)
      + $past(oneshot_compare_offset_ff))
    else $error("compare value is not entry plus offsets");

  mask_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    capture_mask_distance_ff <= `CCE_MASK_DIST_MAX)
    else $error("mask distance beyond maximum");

  mask_block_a: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == CCE_MASK && capture_mask_distance_ff != 32'h0000_0000 &&
     abs_diff(axis_pos, mask_origin_ff) <= capture_mask_distance_ff) |-> !take)
    else $error("capture taken inside masking distance");

  mask_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cap_trig && cap_busy && capture_mask_distance_ff == 32'h0000_0000) |-> take)
    else $error("trigger refused with masking disabled");

  repeat_wrap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (take && last_pt && repeat_en) |=> cap_busy && index_ff == $past(capture_array_start_ff))
    else $error("repeat did not restart at start index");

  stop_last_a: assert property (@(posedge clk_sys) disable iff (rst)
    (take && last_pt && !repeat_en) |=> !cap_busy ##1 !cap_wr.valid)
    else $error("capture continued without repeat");

endmodule

`default_nettype wire

// ---- test/cce_axis_src.sv ----
// Purpose: Axis position source and trigger line feeding the capture side
// Assumes: Bench requests a load one cycle before it fires a trigger
// Notes:   Position holds between loads, so no stale value appears
`timescale 1ns/1ps
`default_nettype none

module cce_axis_src (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [31:0] load_pos,
  input  wire logic        trig_req,
  output var  logic [31:0] axis_pos,
  output var  logic        cap_trig
);
  logic [31:0] pos_ff;

  // Position register, loaded on request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_ff <= 32'h0000_0000;
    end else if (load) begin
      pos_ff <= load_pos;
    end
  end

  // Outputs toward the block
  always_comb begin
    axis_pos = pos_ff;
    cap_trig = trig_req;
  end
endmodule
`default_nettype wire

// ---- test/capture_compare_extras_tb.sv ----
// Purpose: Self-checking bench for the capture/compare extras block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Every answer is checked in the cycle after its request edge
`timescale 1ns/1ps
`default_nettype none
`include "cce_params.svh"

module capture_compare_extras_tb;
  import cce_pkg::*;
  logic clk_sys, rst, cap_start, load, trig_req, cmp_req, par_rvalid, cap_busy;
  logic cap_trig, cmp_valid;
  logic [7:0]   cap_count, cmp_index;
  logic [31:0]  load_pos, axis_pos, par_rdata, eff;
  cce_par_req_t req;
  cce_cap_wr_t  cap_wr;
  int           fail_count, check_count;

  // ==========================================================================
  // Clock, block and partner
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  cce_top uut (.clk_sys(clk_sys), .rst(rst), .par_req(req), .par_rdata(par_rdata),
    .par_rvalid(par_rvalid), .cap_start(cap_start), .cap_count(cap_count),
    .cap_trig(cap_trig), .axis_pos(axis_pos), .cap_wr(cap_wr), .cap_busy(cap_busy),
    .cmp_req(cmp_req), .cmp_index(cmp_index), .effective_compare_value(eff),
    .cmp_valid(cmp_valid));
  cce_axis_src src (.clk_sys(clk_sys), .rst(rst), .load(load), .load_pos(load_pos),
    .trig_req(trig_req), .axis_pos(axis_pos), .cap_trig(cap_trig));

  // ==========================================================================
  // Compare and closing tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Bus, capture and compare drivers
  task automatic par_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys) #1;
    req.wr = 1'b1; req.addr = a; req.wdata = d;
    @(posedge clk_sys) #1;
    req.wr = 1'b0;
  endtask
  task automatic par_rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_sys) #1;
    req.rd = 1'b1; req.addr = a;
    @(posedge clk_sys) #1;
    req.rd = 1'b0;
    chk_bit("par_rvalid", 1'b1, par_rvalid);
    chk("par_rdata", e, par_rdata);
  endtask
  task automatic start_cap(input logic [7:0] n);
    @(posedge clk_sys) #1;
    cap_start = 1'b1; cap_count = n;
    @(posedge clk_sys) #1;
    cap_start = 1'b0;
    chk_bit("cap_busy", 1'b1, cap_busy);
  endtask
  task automatic trig_at(input logic [31:0] p, input logic ev, input logic [7:0] ei);
    @(posedge clk_sys) #1;
    load = 1'b1; load_pos = p;
    @(posedge clk_sys) #1;
    load = 1'b0; trig_req = 1'b1;
    @(posedge clk_sys) #1;
    trig_req = 1'b0;
    chk_bit("cap_wr.valid", ev, cap_wr.valid);
    if (ev) begin
      chk("cap_wr.index", {24'h00_0000, ei}, {24'h00_0000, cap_wr.index});
      chk("cap_wr.pos", p, cap_wr.pos);
    end
  endtask
  task automatic cmp_at(input logic [7:0] i, input logic [31:0] e);
    @(posedge clk_sys) #1;
    cmp_req = 1'b1; cmp_index = i;
    @(posedge clk_sys) #1;
    cmp_req = 1'b0;
    chk_bit("cmp_valid", 1'b1, cmp_valid);
    chk("effective_compare_value", e, eff);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic reset_values();
    par_rd(`CCE_ADDR_MASK_DIST, 32'h0000_0000);
    par_rd(`CCE_ADDR_ONESHOT_OFS, 32'h0000_0000);
    par_rd(16'h0200, 32'h0000_0000);
  endtask
  task automatic mask_limit();
    par_wr(`CCE_ADDR_MASK_DIST, `CCE_MASK_DIST_MAX);
    par_rd(`CCE_ADDR_MASK_DIST, `CCE_MASK_DIST_MAX);
    par_wr(`CCE_ADDR_MASK_DIST, `CCE_MASK_DIST_MAX + 32'h0000_0001);
    par_rd(`CCE_ADDR_MASK_DIST, `CCE_MASK_DIST_MAX);
  endtask
  task automatic masked_capture();
    par_wr(`CCE_ADDR_MASK_DIST, 32'h0000_0032);
    start_cap(8'h02);
    trig_at(32'h0000_0064, 1'b1, 8'h00);
    trig_at(32'h0000_0078, 1'b0, 8'h00);
    trig_at(32'h0000_0096, 1'b0, 8'h00);
    trig_at(32'h0000_00C8, 1'b1, 8'h01);
    chk_bit("cap_busy", 1'b0, cap_busy);
    trig_at(32'h0000_012C, 1'b0, 8'h00);
  endtask
  task automatic oneshot_offset();
    par_wr(`CCE_ADDR_OPTIONS, 32'h0000_0100);
    par_wr(`CCE_ADDR_FIXED_OFS, 32'h0000_03E8);
    par_rd(`CCE_ADDR_FIXED_OFS, 32'h0000_03E8);
    par_wr(`CCE_ADDR_ONESHOT_OFS, 32'h0000_0007);
    cmp_at(8'h00, 32'h0000_0453);
    cmp_at(8'h01, 32'h0000_04B0);
    par_rd(`CCE_ADDR_ONESHOT_OFS, 32'h0000_0000);
    par_wr(`CCE_ADDR_OPTIONS, 32'h0000_0000);
    par_wr(`CCE_ADDR_ONESHOT_OFS, 32'h0000_0007);
    cmp_at(8'h01, 32'h0000_04B7);
    cmp_at(8'h01, 32'h0000_04B7);
    par_rd(`CCE_ADDR_ONESHOT_OFS, 32'h0000_0007);
  endtask
  task automatic repeat_capture();
    par_wr(`CCE_ADDR_OPTIONS, 32'h0000_0101);
    par_rd(`CCE_ADDR_OPTIONS, 32'h0000_0101);
    par_wr(`CCE_ADDR_ARRAY_START, 32'h0000_0005);
    par_wr(`CCE_ADDR_MASK_DIST, 32'h0000_0000);
    start_cap(8'h02);
    trig_at(32'h0000_000A, 1'b1, 8'h05);
    trig_at(32'h0000_000B, 1'b1, 8'h06);
    trig_at(32'h0000_000C, 1'b1, 8'h05);
    chk_bit("cap_busy", 1'b1, cap_busy);
    par_wr(`CCE_ADDR_OPTIONS, 32'h0000_0000);
    trig_at(32'h0000_000D, 1'b1, 8'h06);
    chk_bit("cap_busy", 1'b0, cap_busy);
    par_rd(`CCE_ADDR_ARRAY_START, 32'h0000_0005);
    // Second pass overwrote entry 5; one-shot offset of 7 still held
    cmp_at(8'h05, 32'h0000_03FB);
    par_rd(`CCE_ADDR_CMP_VALUE, 32'h0000_03FB);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    fail_count = 0; check_count = 0;
    rst = 1'b1; req = '0; cap_start = 1'b0; cap_count = 8'h00; load = 1'b0;
    load_pos = 32'h0000_0000; trig_req = 1'b0; cmp_req = 1'b0; cmp_index = 8'h00;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    reset_values();
    mask_limit();
    masked_capture();
    oneshot_offset();
    repeat_capture();
    results();
  end
  initial begin
    #500000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
